// >>> hw/port_direction_pullup_ctrl.sv
// top: byte-wide register file for ports 0, 2, 4, 5, 8 and 9
// ------------------------------------------------------------
// ------------------------------------------------------------
module port_direction_pullup_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    input  wire logic [3:0]  p0_in,
    output logic      [3:0]  p0_out,
    output logic      [3:0]  p0_oe,
    output logic      [3:0]  p0_pullup,
    input  wire logic [7:0]  p2_in,
    output logic      [7:0]  p2_out,
    output logic      [7:0]  p2_oe,
    output logic      [7:0]  p2_pullup,
    input  wire logic [7:0]  p4_in,
    output logic      [7:0]  p4_out,
    output logic      [7:0]  p4_oe,
    output logic      [7:0]  p4_pullup,
    input  wire logic [3:0]  p5_in,
    output logic      [3:0]  p5_out,
    output logic      [3:0]  p5_oe,
    input  wire logic [7:0]  p8_in,
    output logic      [7:0]  p8_out,
    output logic      [7:0]  p8_oe,
    output logic      [7:0]  p8_pullup,
    input  wire logic [3:0]  p9_in,
    output logic      [3:0]  p9_out,
    output logic      [3:0]  p9_oe,
    output logic      [3:0]  p9_pullup,
    output logic             port2_out_change
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hit_d0  = addr == port_ctrl_pkg::port0_direction_addr;
    wire hit_d2  = addr == port_ctrl_pkg::port2_direction_addr;
    wire hit_d4  = addr == port_ctrl_pkg::port4_direction_addr;
    wire hit_d5  = addr == port_ctrl_pkg::port5_direction_addr;
    wire hit_d8  = addr == port_ctrl_pkg::port8_direction_addr;
    wire hit_d9  = addr == port_ctrl_pkg::port9_direction_addr;
    wire hit_l0  = addr == port_ctrl_pkg::port0_data_addr;
    wire hit_l2  = addr == port_ctrl_pkg::port2_data_addr;
    wire hit_l4  = addr == port_ctrl_pkg::port4_data_addr;
    wire hit_l5  = addr == port_ctrl_pkg::port5_data_addr;
    wire hit_l8  = addr == port_ctrl_pkg::port8_data_addr;
    wire hit_l9  = addr == port_ctrl_pkg::port9_data_addr;
    wire hit_pu1 = addr == port_ctrl_pkg::port2_pullup_enable_addr;
    wire hit_pu2 = addr == port_ctrl_pkg::port8_9_pair_pullup_enable_addr;
    wire hit_pu0 = addr == port_ctrl_pkg::port0_4_group_pullup_enable_addr;

    // ------------------------------------------------------------
    // pull-up enable registers
    // ------------------------------------------------------------
    logic [7:0] port0_4_group_pullup_enable_reg;
    logic [7:0] port2_pullup_enable_reg;
    logic [7:0] port8_9_pair_pullup_enable_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            port0_4_group_pullup_enable_reg <= port_ctrl_pkg::pullup_reset;
            port2_pullup_enable_reg         <= port_ctrl_pkg::pullup_reset;
            port8_9_pair_pullup_enable_reg  <= port_ctrl_pkg::pullup_reset;
        end else if (wr_en) begin
            // bits software must keep at zero are stored as written
            if (hit_pu0)
                port0_4_group_pullup_enable_reg <= wr_data;
            if (hit_pu1)
                port2_pullup_enable_reg <= wr_data;
            if (hit_pu2)
                port8_9_pair_pullup_enable_reg <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // pull-up fan-out to pins
    // ------------------------------------------------------------
    wire       grp0 = port0_4_group_pullup_enable_reg
                      [port_ctrl_pkg::group_port0_bit];
    wire       grp4 = port0_4_group_pullup_enable_reg
                      [port_ctrl_pkg::group_port4_bit];
    wire [3:0] pair8 = port8_9_pair_pullup_enable_reg
                       [port_ctrl_pkg::pair_port8_lsb +: 4];
    wire [1:0] pair9 = port8_9_pair_pullup_enable_reg
                       [port_ctrl_pkg::pair_port9_lsb +: 2];
    wire [3:0] req0 = {4{grp0}};
    wire [7:0] req4 = {8{grp4}};
    wire [7:0] req8 = {{2{pair8[3]}}, {2{pair8[2]}},
                       {2{pair8[1]}}, {2{pair8[0]}}};
    wire [3:0] req9 = {{2{pair9[1]}}, {2{pair9[0]}}};

    // ------------------------------------------------------------
    // ports
    // ------------------------------------------------------------
    logic [3:0] dir0;
    logic [7:0] dir2;
    logic [7:0] dir4;
    logic [3:0] dir5;
    logic [7:0] dir8;
    logic [3:0] dir9;
    logic [3:0] val0;
    logic [7:0] val2;
    logic [7:0] val4;
    logic [3:0] val5;
    logic [7:0] val8;
    logic [3:0] val9;

    // a bit operation on a port arrives here as a whole-byte write,
    // so untouched input pins take whatever the cpu read back
    port_pin_cell #(.width(4)) u_p0 (
        .core_clk(core_clk), .rst(rst),
        .dir_wr(wr_en & hit_d0), .dat_wr(wr_en & hit_l0),
        .wr_data(wr_data), .pullup_req(req0), .pin_in(p0_in),
        .pin_out(p0_out), .pin_oe(p0_oe), .pin_pullup(p0_pullup),
        .dir_q(dir0), .rd_value(val0), .out_change());
    port_pin_cell #(.width(8)) u_p2 (
        .core_clk(core_clk), .rst(rst),
        .dir_wr(wr_en & hit_d2), .dat_wr(wr_en & hit_l2),
        .wr_data(wr_data), .pullup_req(port2_pullup_enable_reg),
        .pin_in(p2_in),
        .pin_out(p2_out), .pin_oe(p2_oe), .pin_pullup(p2_pullup),
        .dir_q(dir2), .rd_value(val2),
        .out_change(port2_out_change));
    port_pin_cell #(.width(8)) u_p4 (
        .core_clk(core_clk), .rst(rst),
        .dir_wr(wr_en & hit_d4), .dat_wr(wr_en & hit_l4),
        .wr_data(wr_data), .pullup_req(req4), .pin_in(p4_in),
        .pin_out(p4_out), .pin_oe(p4_oe), .pin_pullup(p4_pullup),
        .dir_q(dir4), .rd_value(val4), .out_change());
    // port 5 has no software pull-up
    port_pin_cell #(.width(4)) u_p5 (
        .core_clk(core_clk), .rst(rst),
        .dir_wr(wr_en & hit_d5), .dat_wr(wr_en & hit_l5),
        .wr_data(wr_data), .pullup_req(4'h0), .pin_in(p5_in),
        .pin_out(p5_out), .pin_oe(p5_oe), .pin_pullup(),
        .dir_q(dir5), .rd_value(val5), .out_change());
    port_pin_cell #(.width(8)) u_p8 (
        .core_clk(core_clk), .rst(rst),
        .dir_wr(wr_en & hit_d8), .dat_wr(wr_en & hit_l8),
        .wr_data(wr_data), .pullup_req(req8), .pin_in(p8_in),
        .pin_out(p8_out), .pin_oe(p8_oe), .pin_pullup(p8_pullup),
        .dir_q(dir8), .rd_value(val8), .out_change());
    port_pin_cell #(.width(4)) u_p9 (
        .core_clk(core_clk), .rst(rst),
        .dir_wr(wr_en & hit_d9), .dat_wr(wr_en & hit_l9),
        .wr_data(wr_data), .pullup_req(req9), .pin_in(p9_in),
        .pin_out(p9_out), .pin_oe(p9_oe), .pin_pullup(p9_pullup),
        .dir_q(dir9), .rd_value(val9), .out_change());

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [7:0] up = port_ctrl_pkg::narrow_upper_one;
    wire [7:0] rd_sel =
        hit_d0  ? (up | {4'h0, dir0}) :
        hit_d2  ? dir2 :
        hit_d4  ? dir4 :
        hit_d5  ? (up | {4'h0, dir5}) :
        hit_d8  ? dir8 :
        hit_d9  ? (up | {4'h0, dir9}) :
        hit_l0  ? {4'h0, val0} :
        hit_l2  ? val2 :
        hit_l4  ? val4 :
        hit_l5  ? {4'h0, val5} :
        hit_l8  ? val8 :
        hit_l9  ? {4'h0, val9} :
        hit_pu0 ? port0_4_group_pullup_enable_reg :
        hit_pu1 ? port2_pullup_enable_reg :
        hit_pu2 ? port8_9_pair_pullup_enable_reg :
                  port_ctrl_pkg::read_unmapped;

    logic [7:0] rd_data_reg;

    always_ff @(posedge core_clk) begin
        if (rst)
            rd_data_reg <= port_ctrl_pkg::read_unmapped;
        else if (rd_en)
            rd_data_reg <= rd_sel;
    end

    assign rd_data = rd_data_reg;

endmodule

// >>> hw/port_ctrl_pkg.sv
// package: register map, reset values and field positions of the port block
package port_ctrl_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] port0_direction_addr             = 16'hff20;
    localparam logic [15:0] port2_direction_addr             = 16'hff22;
    localparam logic [15:0] port4_direction_addr             = 16'hff24;
    localparam logic [15:0] port5_direction_addr             = 16'hff25;
    localparam logic [15:0] port8_direction_addr             = 16'hff28;
    localparam logic [15:0] port9_direction_addr             = 16'hff29;
    localparam logic [15:0] port2_pullup_enable_addr         = 16'hfff3;
    localparam logic [15:0] port8_9_pair_pullup_enable_addr  = 16'hfff4;
    localparam logic [15:0] port0_4_group_pullup_enable_addr = 16'hfff7;
    // port data latches sit at the low page, one per port number
    localparam logic [15:0] port0_data_addr                  = 16'hff00;
    localparam logic [15:0] port2_data_addr                  = 16'hff02;
    localparam logic [15:0] port4_data_addr                  = 16'hff04;
    localparam logic [15:0] port5_data_addr                  = 16'hff05;
    localparam logic [15:0] port8_data_addr                  = 16'hff08;
    localparam logic [15:0] port9_data_addr                  = 16'hff09;

    // ------------------------------------------------------------
    // reset values and fixed bits
    // ------------------------------------------------------------
    localparam logic [7:0] direction_reset  = 8'hff;
    localparam logic [7:0] pullup_reset     = 8'h00;
    localparam logic [7:0] latch_reset      = 8'h00;
    localparam logic [7:0] narrow_upper_one = 8'hf0;
    localparam logic [7:0] read_unmapped    = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int group_port0_bit = 0;
    localparam int group_port4_bit = 4;
    localparam int pair_port8_lsb  = 0;
    localparam int pair_port9_lsb  = 4;

endpackage

// >>> hw/port_pin_cell.sv
// one port: output latch, direction, pull-up gating and pin sampling
module port_pin_cell #(
    parameter int width = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             dir_wr,
    input  wire logic             dat_wr,
    input  wire logic [7:0]       wr_data,
    input  wire logic [width-1:0] pullup_req,
    input  wire logic [width-1:0] pin_in,
    output logic      [width-1:0] pin_out,
    output logic      [width-1:0] pin_oe,
    output logic      [width-1:0] pin_pullup,
    output logic      [width-1:0] dir_q,
    output logic      [width-1:0] rd_value,
    output logic                  out_change
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [width-1:0] dir_reg;
    logic [width-1:0] latch_reg;
    logic [width-1:0] sync1_reg;
    logic [width-1:0] sync2_reg;
    logic [width-1:0] sync3_reg;
    logic [width-1:0] pin_level_reg;
    logic [width-1:0] drive_reg;
    logic [width-1:0] oe_reg;
    logic [width-1:0] pull_reg;
    logic [width-1:0] agree;
    logic [width-1:0] level_next;
    logic [width-1:0] drive_next;

    assign agree      = ~(sync2_reg ^ sync3_reg);
    assign level_next = (sync2_reg & agree) | (pin_level_reg & ~agree);
    assign drive_next = latch_reg & ~dir_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dir_reg   <= port_ctrl_pkg::direction_reset[width-1:0];
            latch_reg <= port_ctrl_pkg::latch_reset[width-1:0];
        end else begin
            if (dir_wr)
                dir_reg <= wr_data[width-1:0];
            if (dat_wr)
                latch_reg <= wr_data[width-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_reg     <= '0;
            sync2_reg     <= '0;
            sync3_reg     <= '0;
            pin_level_reg <= '0;
            drive_reg     <= '0;
            oe_reg        <= '0;
            pull_reg      <= '0;
        end else begin
            sync1_reg     <= pin_in;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            pin_level_reg <= level_next;
            drive_reg     <= drive_next;
            oe_reg        <= ~dir_reg;
            pull_reg      <= pullup_req & dir_reg;
        end
    end

    assign pin_out    = drive_reg;
    assign pin_oe     = oe_reg;
    assign pin_pullup = pull_reg;
    assign dir_q      = dir_reg;
    // output pins give back the latch, input pins the sampled level
    assign rd_value   = (latch_reg & ~dir_reg) |
                        (pin_level_reg & dir_reg);
    // a driven level that moves is flagged in the cycle before it reaches the pin
    assign out_change = |((drive_next ^ drive_reg) & ~dir_reg);

endmodule

// >>> testbench/port_ctrl_sva.sv
// checker: timing and gating properties of the port block
module port_ctrl_sva (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic        port2_out_change,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wr_data,
    input wire logic [7:0]  rd_data,
    input wire logic [7:0]  p2_out,
    input wire logic [7:0]  p2_oe,
    input wire logic [7:0]  p2_pullup,
    input wire logic [7:0]  p4_out,
    input wire logic [7:0]  p4_oe,
    input wire logic [7:0]  p4_pullup
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    dir_write_a: assert property (disable iff (rst)
        wr_en && addr == 16'hff22 ##1 !(wr_en && addr == 16'hff22)
        |=> p2_oe == ~$past(wr_data, 2))
        else $error("port 2 enables do not follow direction write");
    dir_read_a: assert property (disable iff (rst)
        rd_en && addr == 16'hff24 |=> rd_data == ~p4_oe)
        else $error("port 4 direction read disagrees with enables");
    narrow_read_a: assert property (disable iff (rst)
        rd_en && (addr == 16'hff20 || addr == 16'hff25 || addr == 16'hff29)
        |=> rd_data[7:4] == 4'hf)
        else $error("narrow direction upper bits not ones");
    reset_state_a: assert property (disable iff (rst)
        $fell(rst) |-> p2_oe == 8'h00 && p4_oe == 8'h00
        && p2_pullup == 8'h00 && p4_pullup == 8'h00)
        else $error("outputs not in reset state after reset");
    pullup_gate_a: assert property (disable iff (rst)
        (p2_pullup & p2_oe) == 8'h00 && (p4_pullup & p4_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    out_gate_a: assert property (disable iff (rst)
        (p2_out & ~p2_oe) == 8'h00 && (p4_out & ~p4_oe) == 8'h00)
        else $error("level presented on a released pin");
    rd_hold_a: assert property (disable iff (rst)
        !rd_en |=> $stable(rd_data))
        else $error("read data changed without a read");
    change_flag_a: assert property (disable iff (rst)
        port2_out_change |=> (p2_out & p2_oe) != ($past(p2_out) & $past(p2_oe)))
        else $error("port 2 change flag without a level change");
endmodule

bind port_direction_pullup_ctrl port_ctrl_sva chk (
    .core_clk(core_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
    .port2_out_change(port2_out_change), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .p2_out(p2_out), .p2_oe(p2_oe),
    .p2_pullup(p2_pullup), .p4_out(p4_out), .p4_oe(p4_oe),
    .p4_pullup(p4_pullup));

// >>> testbench/pin_world.sv
// partner: resolves pin levels from driver, pull-up and outside drive
module pin_world (
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] pu,
    input  wire logic [7:0] ext,
    output logic      [7:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pins go to the pull-up level, else the outside drive
    assign lvl = (oe & out) | (~oe & (pu | ext));
endmodule

// >>> testbench/testbench.sv
// testbench: random register and pin traffic against a reference model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, wr_en, rd_en;
    logic [15:0] addr, a;
    logic [7:0]  wr_data, d, q, ext[6], m_dir[6], m_lat[6], m_pu[3];
    wire  [7:0]  rd_data, po[6], oe[6], pu[6], lv[6];
    wire         chg;
    logic [31:0] seed;
    int          fails, num_checks;
    int          pn[6] = '{0, 2, 4, 5, 8, 9};
    logic [7:0]  wm[6] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f};
    logic [15:0] am[16] = '{16'hff20, 16'hff22, 16'hff24, 16'hff25,
        16'hff28, 16'hff29, 16'hfff3, 16'hfff4, 16'hfff7, 16'hff00,
        16'hff02, 16'hff04, 16'hff05, 16'hff08, 16'hff09, 16'hff30};
    port_direction_pullup_ctrl dut (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
        .p0_in(lv[0][3:0]), .p0_out(po[0][3:0]), .p0_oe(oe[0][3:0]),
        .p0_pullup(pu[0][3:0]),
        .p2_in(lv[1]), .p2_out(po[1]), .p2_oe(oe[1]), .p2_pullup(pu[1]),
        .p4_in(lv[2]), .p4_out(po[2]), .p4_oe(oe[2]), .p4_pullup(pu[2]),
        .p5_in(lv[3][3:0]), .p5_out(po[3][3:0]), .p5_oe(oe[3][3:0]),
        .p8_in(lv[4]), .p8_out(po[4]), .p8_oe(oe[4]), .p8_pullup(pu[4]),
        .p9_in(lv[5][3:0]), .p9_out(po[5][3:0]), .p9_oe(oe[5][3:0]),
        .p9_pullup(pu[5][3:0]), .port2_out_change(chg));
    assign pu[3] = 8'h00;
    // narrow ports leave the upper half of each pin vector idle
    assign po[0][7:4] = 4'h0;
    assign oe[0][7:4] = 4'h0;
    assign pu[0][7:4] = 4'h0;
    assign po[3][7:4] = 4'h0;
    assign oe[3][7:4] = 4'h0;
    assign po[5][7:4] = 4'h0;
    assign oe[5][7:4] = 4'h0;
    assign pu[5][7:4] = 4'h0;
    for (genvar i = 0; i < 6; i++) begin : g_pin
        pin_world w (.out(po[i]), .oe(oe[i]), .pu(pu[i]), .ext(ext[i]),
                     .lvl(lv[i]));
    end
    always #5 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] pu_exp(input int i);
        logic [7:0] e;
        case (i)
            0: e = {8{m_pu[2][0]}};
            1: e = m_pu[0];
            2: e = {8{m_pu[2][4]}};
            4: e = {{2{m_pu[1][3]}}, {2{m_pu[1][2]}}, {2{m_pu[1][1]}},
                    {2{m_pu[1][0]}}};
            5: e = {4'h0, {2{m_pu[1][5]}}, {2{m_pu[1][4]}}};
            default: e = 8'h00;
        endcase
        return e & m_dir[i] & wm[i];
    endfunction
    function automatic logic [7:0] rd_exp(input logic [15:0] x);
        for (int i = 0; i < 6; i++) begin
            if (x == 16'hff20 + pn[i]) return m_dir[i] | ~wm[i];
            if (x == 16'hff00 + pn[i]) return wm[i] & ((m_lat[i] & ~m_dir[i])
                | (m_dir[i] & (pu_exp(i) | ext[i])));
        end
        if (x == 16'hfff3) return m_pu[0];
        if (x == 16'hfff4) return m_pu[1];
        if (x == 16'hfff7) return m_pu[2];
        return 8'h00;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] x,
                       input logic [7:0] v, output logic [7:0] r);
        logic [7:0] e_old;
        logic [7:0] e_new;
        e_old = m_lat[1] & ~m_dir[1];
        @(posedge core_clk) #1;
        wr_en = w;
        rd_en = !w;
        addr = x;
        wr_data = v;
        @(posedge core_clk) #1;
        wr_en = 0;
        rd_en = 0;
        r = rd_data;
        for (int i = 0; i < 6 && w; i++) begin
            if (x == 16'hff20 + pn[i]) m_dir[i] = v;
            if (x == 16'hff00 + pn[i]) m_lat[i] = v;
        end
        if (w && x == 16'hfff3) m_pu[0] = v;
        if (w && x == 16'hfff4) m_pu[1] = v;
        if (w && x == 16'hfff7) m_pu[2] = v;
        // a moved driven level on port 2 flags in the cycle after the write
        e_new = m_lat[1] & ~m_dir[1];
        chk({7'h0, chg}, {7'h0, |((e_new ^ e_old) & ~m_dir[1])});
    endtask
    task automatic check_all;
        logic [7:0] r;
        repeat (6) @(posedge core_clk);
        #1;
        for (int i = 0; i < 6; i++) begin
            chk(oe[i] & wm[i], ~m_dir[i] & wm[i]);
            chk(po[i] & wm[i], m_lat[i] & ~m_dir[i] & wm[i]);
            chk(pu[i] & wm[i], pu_exp(i));
        end
        for (int k = 0; k < 16; k++) begin
            bus(0, am[k], 8'h00, r);
            chk(r, rd_exp(am[k]));
        end
    endtask
    task automatic reset_all;
        rst = 1;
        repeat (3) @(posedge core_clk);
        #1 rst = 0;
        m_dir = '{6{8'hff}};
        m_lat = '{6{8'h00}};
        m_pu = '{3{8'h00}};
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        wr_en = 0;
        rd_en = 0;
        addr = 16'h0000;
        wr_data = 8'h00;
        ext = '{6{8'h00}};
        seed = 32'he4b7;
        reset_all;
        check_all;
        for (int n = 0; n < 80; n++) begin
            repeat (8) seed = lfsr(seed);
            a = am[seed[3:0]];
            d = seed[15:8];
            if (a == 16'hfff7) d = d & 8'h11;
            if (a == 16'hfff4) d = d & 8'h3f;
            ext[n % 6] = seed[31:24];
            bus(1, a, d, q);
            check_all;
        end
        for (int i = 0; i < 6; i++) begin
            bus(0, 16'(16'hff00 + pn[i]), 8'h00, q);
            bus(1, 16'(16'hff00 + pn[i]), q ^ (8'h01 << i), q);
            check_all;
        end
        bus(1, 16'hff02, 8'h00, q);
        bus(1, 16'hff22, 8'hf7, q);
        bus(1, 16'hff24, 8'h3f, q);
        check_all;
        reset_all;
        check_all;
        print_verdict;
    end
    initial begin
        #300000;
        fails++;
        print_verdict;
    end
endmodule
